// >>> shared/rcs_map.svh
// Constants for the reset control sequencer: timing counts and field positions.
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH

// ----------------------------------------------------------------------------
// Timing counts in system clock cycles
// ----------------------------------------------------------------------------
`define RCS_TURN_CYCLES 10'h002
`define RCS_DRIVE_CYCLES 10'h200
`define RCS_RELEASE_CYCLES 10'h00A
`define RCS_RISE_CYCLES 10'h0B4
`define RCS_MODULE_RESET_CYCLES 3'h4
`define RCS_BUS_TIMEOUT_CYCLES 10'h040

// ----------------------------------------------------------------------------
// Reset cause register bit positions
// ----------------------------------------------------------------------------
`define RCS_CAUSE_POR 0
`define RCS_CAUSE_EXT 1
`define RCS_CAUSE_INT_BASE 2

// ----------------------------------------------------------------------------
// Reset values loaded on master reset
// ----------------------------------------------------------------------------
`define RCS_IPL_MASK_RESET 3'h7
`define RCS_VECTOR_BASE_RESET 32'h0000_0000

`endif

// >>> shared/rcs_pkg.sv
// Types shared by the reset control sequencer modules.
package rcs_pkg;

	// ------------------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		RCS_POR,
		RCS_IDLE,
		RCS_WAIT_BUS,
		RCS_TURN,
		RCS_DRIVE,
		RCS_RELEASE,
		RCS_RISE,
		RCS_DONE
	} rcs_state_t;

	// Width of the sequencing counter.
	typedef logic [9:0] rcs_count_t;

endpackage : rcs_pkg

// >>> rtl/rcs_sync2.sv
// Two flip-flop synchroniser for a group of inputs from outside the clock.
module rcs_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule : rcs_sync2

// >>> rtl/rcs_cycle_counter.sv
// Loadable down counter that flags when it has run out.
module rcs_cycle_counter (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_load,
	input wire rcs_pkg::rcs_count_t i_value,
	output logic o_zero
);
	import rcs_pkg::*;

	rcs_count_t count_q;
	rcs_count_t count_d;

	// A load wins over counting; the count holds at zero.
	assign count_d = i_load ? i_value :
		(count_q == '0) ? count_q : count_q - 10'h001;
	assign o_zero = (count_q == '0);

	// Counter register.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

endmodule : rcs_cycle_counter

// >>> rtl/rcs_top.sv
// Reset control sequencer: reset pin, master reset, core reset state, causes.
`include "rcs_map.svh"

module rcs_top #(
	parameter int N_INT = 3,
	parameter int BUS_TIMEOUT = 64
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_reset_pin,
	input wire logic [N_INT-1:0] i_internal_reset_src,
	input wire logic i_bus_cycle_end,
	input wire logic i_pll_lock,
	input wire logic [15:0] i_data_bus,
	input wire logic i_bus_error_input_n,
	input wire logic i_three_state_control,
	input wire logic i_breakpoint_request_n,
	output logic o_reset_pin_out,
	output logic o_reset_pin_oe,
	output logic o_master_reset,
	output logic o_module_reset,
	output logic o_abort,
	output logic o_pins_inactive,
	output logic o_port_high_z,
	output logic o_drivers_disabled,
	output logic [15:0] o_config_data,
	output logic o_config_bus_error,
	output logic [N_INT+1:0] o_reset_cause_register,
	output logic o_trace_bit_low,
	output logic o_trace_bit_high,
	output logic o_supervisor,
	output logic [2:0] o_ipl_mask,
	output logic [31:0] o_vector_base_register,
	output logic o_bdm_enable,
	output logic o_vector_fetch,
	output logic o_boot_chip_select_n
);
	import rcs_pkg::*;

	localparam int NC = N_INT + 2;

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------

	// Keeps only the lowest set bit, so one cause wins.
	function automatic logic [NC-1:0] pick_one(input logic [NC-1:0] v);
		logic [NC-1:0] r;
		r = '0;
		for (int k = NC - 1; k >= 0; k--) begin
			if (v[k]) begin
				r = '0;
				r[k] = 1'b1;
			end
		end
		return r;
	endfunction : pick_one

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------

	logic [20:0] raw_in;
	logic [20:0] sync_in;
	logic pin_s;
	logic lock_s;
	logic three_state_s;
	logic brk_n_s;
	logic bus_err_n_s;
	logic [15:0] data_s;

	// Every pin passes two flip-flops before the sequencer reads it.
	assign raw_in = {i_reset_pin, i_pll_lock, i_three_state_control,
		i_breakpoint_request_n, i_bus_error_input_n, i_data_bus};

	rcs_sync2 #(
		.WIDTH(21)
	) u_sync (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_async(raw_in),
		.o_sync(sync_in)
	);

	assign pin_s = sync_in[20];
	assign lock_s = sync_in[19];
	assign three_state_s = sync_in[18];
	assign brk_n_s = sync_in[17];
	assign bus_err_n_s = sync_in[16];
	assign data_s = sync_in[15:0];

	// ------------------------------------------------------------------------
	// State and counters
	// ------------------------------------------------------------------------

	rcs_state_t st_q;
	rcs_state_t st_d;
	logic cnt_load;
	rcs_count_t cnt_value;
	logic cnt_zero;
	logic [9:0] bus_wait_q;
	logic [9:0] bus_wait_d;
	logic [2:0] mr_cnt_q;
	logic [2:0] mr_cnt_d;
	logic [NC-1:0] pend_q;
	logic [NC-1:0] pend_d;
	logic three_state_q;
	logic [15:0] cfg_q;
	logic cfg_bus_err_q;
	logic [NC-1:0] cause_q;
	logic bdm_q;
	logic fetch_q;
	logic boot_n_q;
	logic abort_q;
	logic master_q;
	logic oe_q;
	logic pin_out_q;

	rcs_cycle_counter u_cnt (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_load(cnt_load),
		.i_value(cnt_value),
		.o_zero(cnt_zero)
	);

	// ------------------------------------------------------------------------
	// Request detection
	// ------------------------------------------------------------------------

	logic int_req;
	logic ext_req;
	logic bus_ok;
	logic [NC-1:0] raw_cause;
	logic start_rel;

	// Internal sources share the clock; the pin is read only synchronised.
	assign int_req = |i_internal_reset_src;
	assign ext_req = ~pin_s;
	assign raw_cause = {i_internal_reset_src, ext_req, 1'b0};
	// Acting waits for the bus cycle to end or the wait to time out.
	assign bus_ok = i_bus_cycle_end ||
		(bus_wait_q == 10'(BUS_TIMEOUT - 1));
	// The release window opens when the drive period has run out and no internal source asks.
	assign start_rel = (st_q == RCS_DRIVE) && cnt_zero && !int_req;

	// ------------------------------------------------------------------------
	// Sequencer next state
	// ------------------------------------------------------------------------

	// Chooses the next phase and loads the phase counter on entry.
	always_comb begin
		st_d = st_q;
		cnt_load = 1'b0;
		cnt_value = '0;
		case (st_q)
			RCS_POR: begin
				// Resets stay asserted until lock, then 512 drive cycles and the release window.
				if (lock_s) begin
					st_d = RCS_DRIVE;
					cnt_load = 1'b1;
					cnt_value = `RCS_DRIVE_CYCLES - 10'h001;
				end
			end
			RCS_IDLE: begin
				if (int_req || ext_req) begin
					st_d = RCS_WAIT_BUS;
				end
			end
			RCS_WAIT_BUS: begin
				if (bus_ok) begin
					st_d = RCS_TURN;
					cnt_load = 1'b1;
					cnt_value = `RCS_TURN_CYCLES - 10'h001;
				end
			end
			RCS_TURN: begin
				if (cnt_zero) begin
					st_d = RCS_DRIVE;
					cnt_load = 1'b1;
					cnt_value = `RCS_DRIVE_CYCLES - 10'h001;
				end
			end
			RCS_DRIVE: begin
				// Driving continues while an internal source still asks.
				if (start_rel) begin
					st_d = RCS_RELEASE;
					cnt_load = 1'b1;
					cnt_value = `RCS_RELEASE_CYCLES - 10'h001;
				end
			end
			RCS_RELEASE: begin
				if (cnt_zero) begin
					if (pin_s) begin
						st_d = RCS_DONE;
					end else begin
						st_d = RCS_RISE;
						cnt_load = 1'b1;
						cnt_value = `RCS_RISE_CYCLES - 10'h001;
					end
				end
			end
			RCS_RISE: begin
				if (pin_s) begin
					st_d = RCS_DONE;
				end else if (cnt_zero) begin
					st_d = RCS_TURN;
					cnt_load = 1'b1;
					cnt_value = `RCS_TURN_CYCLES - 10'h001;
				end
			end
			RCS_DONE: begin
				st_d = RCS_IDLE;
			end
			default: begin
				st_d = RCS_POR;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// Derived next values
	// ------------------------------------------------------------------------

	logic master_d;
	logic oe_d;
	logic enter_reset;
	logic off_d;
	logic boot_n_d;
	logic mod_rst_q;

	// Three-state control, already seen or arriving, turns drivers off.
	assign off_d = three_state_q || three_state_s;

	// Master reset spans from the end of the bus wait until the pin is seen high.
	assign master_d = (st_d != RCS_IDLE) && (st_d != RCS_WAIT_BUS) &&
		(st_d != RCS_DONE);
	// The pin is driven only in the drive phases and never when off.
	assign oe_d = ((st_d == RCS_POR) || (st_d == RCS_DRIVE)) &&
		!off_d;
	assign enter_reset = (st_q == RCS_WAIT_BUS) && bus_ok;
	assign bus_wait_d = (st_q == RCS_WAIT_BUS) ? bus_wait_q + 10'h001 : '0;
	// Module reset follows four cycles of running master reset.
	assign mr_cnt_d = !master_q ? 3'h0 :
		(mr_cnt_q == `RCS_MODULE_RESET_CYCLES) ? mr_cnt_q :
		mr_cnt_q + 3'h1;
	// The first cause seen is kept; later ones do not add bits.
	assign pend_d = (st_q == RCS_IDLE) ? pick_one(raw_cause) :
		pend_q;
	// Boot select opens at negation and closes again under reset.
	assign boot_n_d = (st_q == RCS_DONE) ? off_d :
		(master_d || boot_n_q || off_d);

	// ------------------------------------------------------------------------
	// Sequencer registers
	// ------------------------------------------------------------------------

	// State, pin drive and reset outputs.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st_q <= RCS_POR;
			oe_q <= 1'b1;
			master_q <= 1'b1;
			pin_out_q <= 1'b0;
			bus_wait_q <= '0;
			mr_cnt_q <= '0;
			abort_q <= 1'b0;
			mod_rst_q <= 1'b0;
		end else begin
			st_q <= st_d;
			oe_q <= oe_d;
			master_q <= master_d;
			pin_out_q <= 1'b0;
			bus_wait_q <= bus_wait_d;
			mr_cnt_q <= mr_cnt_d;
			abort_q <= enter_reset;
			mod_rst_q <= (mr_cnt_d == `RCS_MODULE_RESET_CYCLES);
		end
	end

	// Three-state control is sticky until the next power-on reset.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			three_state_q <= 1'b0;
		end else begin
			three_state_q <= off_d;
		end
	end

	// Operating configuration latched as the release window opens.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			cfg_q <= '0;
			cfg_bus_err_q <= 1'b0;
		end else if (start_rel) begin
			cfg_q <= data_s;
			cfg_bus_err_q <= ~bus_err_n_s;
		end
	end

	// Pending cause, taken while idle, and cause register, updated when the pin is seen high.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			pend_q <= NC'(1) << `RCS_CAUSE_POR;
			cause_q <= '0;
		end else begin
			pend_q <= pend_d;
			if (st_q == RCS_DONE) begin
				cause_q <= pend_q;
			end
		end
	end

	// Breakpoint sample, vector fetch and boot select on negation.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			bdm_q <= 1'b0;
			fetch_q <= 1'b0;
			boot_n_q <= 1'b1;
		end else begin
			fetch_q <= (st_q == RCS_DONE);
			boot_n_q <= boot_n_d;
			if (st_q == RCS_DONE) begin
				bdm_q <= ~brk_n_s;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------

	// Core state on master reset is fixed, so it is driven as constants.
	assign o_trace_bit_low = 1'b0;
	assign o_trace_bit_high = 1'b0;
	assign o_supervisor = 1'b1;
	assign o_ipl_mask = `RCS_IPL_MASK_RESET;
	assign o_vector_base_register = `RCS_VECTOR_BASE_RESET;

	assign o_reset_pin_out = pin_out_q;
	assign o_reset_pin_oe = oe_q;
	assign o_master_reset = master_q;
	assign o_module_reset = mod_rst_q;
	assign o_abort = abort_q;
	assign o_pins_inactive = master_q;
	assign o_port_high_z = master_q;
	assign o_drivers_disabled = three_state_q;
	assign o_config_data = cfg_q;
	assign o_config_bus_error = cfg_bus_err_q;
	assign o_reset_cause_register = cause_q;
	assign o_bdm_enable = bdm_q;
	assign o_vector_fetch = fetch_q;
	assign o_boot_chip_select_n = boot_n_q;

endmodule : rcs_top

// >>> dv/rcs_ext_reset.sv
// Partner model: outside reset circuitry sharing the open-drain reset wire.
module rcs_ext_reset (
	input wire logic i_clock,
	input wire logic i_oe,
	input wire logic i_pull,
	input wire logic [8:0] i_lag,
	output logic o_wire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic oe_q = 1'b0;
	logic [8:0] lag_q = 9'h000;
	// A slow wire stays low for a while after the device lets go.
	always @(posedge i_clock) begin
		oe_q <= i_oe;
		if (oe_q && !i_oe) begin
			lag_q <= i_lag;
		end else if (lag_q != 9'h000) begin
			lag_q <= lag_q - 9'h001;
		end
	end
	// The pull-up wins whenever nobody pulls the wire low; a slow wire
	// is already low in the cycle the device lets go.
	assign o_wire = !(i_oe || i_pull || lag_q != 9'h000 ||
		(oe_q && !i_oe && i_lag != 9'h000));
endmodule : rcs_ext_reset

// >>> dv/rcs_chk.sv
// Checker for the port timing of the reset control sequencer.
module rcs_chk #(
	parameter int N_INT = 3
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [N_INT-1:0] i_internal_reset_src,
	input wire logic o_reset_pin_oe,
	input wire logic o_master_reset,
	input wire logic o_module_reset,
	input wire logic o_abort,
	input wire logic o_drivers_disabled,
	input wire logic [N_INT+1:0] o_reset_cause_register,
	input wire logic o_trace_bit_low,
	input wire logic o_trace_bit_high,
	input wire logic o_supervisor,
	input wire logic [2:0] o_ipl_mask,
	input wire logic [31:0] o_vector_base_register,
	input wire logic o_vector_fetch,
	input wire logic o_boot_chip_select_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] drv_q;
	logic [9:0] drv_d;
	// Counts the cycles the device has driven the wire low, saturating.
	assign drv_d = (drv_q == 10'h3FF) ? drv_q : drv_q + 10'h001;
	always_ff @(posedge i_clock) begin
		drv_q <= (i_rst || !o_reset_pin_oe) ? 10'h000 : drv_d;
	end
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);
	a_drive_min: assert property (
		$fell(o_reset_pin_oe) |-> drv_q >= 10'h1FF)
		else $error("Reset wire released too early.");
	a_release_window: assert property (
		$fell(o_reset_pin_oe) |-> !o_reset_pin_oe[*8] ##1 !o_reset_pin_oe[*2])
		else $error("Release window shorter than ten cycles.");
	a_turn_delay: assert property (
		$rose(o_abort) && !o_drivers_disabled |->
		!o_reset_pin_oe ##1 !o_reset_pin_oe ##1 o_reset_pin_oe)
		else $error("Wire turnaround not two cycles.");
	a_abort_master: assert property (
		o_abort |-> o_master_reset ##1 !o_abort)
		else $error("Abort pulse wrong.");
	a_hold_internal: assert property (
		o_reset_pin_oe && (|i_internal_reset_src) |=> o_reset_pin_oe)
		else $error("Wire released while internal request active.");
	a_module_delay: assert property (
		o_module_reset |-> $past(o_master_reset, 3) && $past(o_master_reset, 2))
		else $error("Module reset before four master cycles.");
	a_fetch_pulse: assert property (
		$rose(o_vector_fetch) |->
		!o_master_reset && !o_boot_chip_select_n ##1 !o_vector_fetch)
		else $error("Vector fetch pulse wrong.");
	a_cause_single: assert property (
		$onehot0(o_reset_cause_register))
		else $error("More than one cause bit set.");
	a_core_state: assert property (
		o_master_reset |-> !o_trace_bit_low && !o_trace_bit_high &&
		o_supervisor && o_ipl_mask == 3'h7 && o_vector_base_register == 32'h0)
		else $error("Core reset state wrong.");
	a_three_state_off: assert property (
		o_drivers_disabled |-> !o_reset_pin_oe && o_boot_chip_select_n)
		else $error("Driver active under three-state control.");
	c_fetch: cover property ($rose(o_vector_fetch));
	c_abort: cover property ($rose(o_abort));
	c_three_state: cover property ($rose(o_drivers_disabled));
	c_module_reset: cover property ($rose(o_module_reset));
endmodule : rcs_chk

bind rcs_top rcs_chk #(.N_INT(N_INT)) rcs_chk_inst (
	.i_clock(i_clock), .i_rst(i_rst),
	.i_internal_reset_src(i_internal_reset_src),
	.o_reset_pin_oe(o_reset_pin_oe), .o_master_reset(o_master_reset),
	.o_module_reset(o_module_reset), .o_abort(o_abort),
	.o_drivers_disabled(o_drivers_disabled),
	.o_reset_cause_register(o_reset_cause_register),
	.o_trace_bit_low(o_trace_bit_low), .o_trace_bit_high(o_trace_bit_high),
	.o_supervisor(o_supervisor), .o_ipl_mask(o_ipl_mask),
	.o_vector_base_register(o_vector_base_register),
	.o_vector_fetch(o_vector_fetch),
	.o_boot_chip_select_n(o_boot_chip_select_n)
);

// >>> dv/tb_top.sv
// Testbench: runs every reset path of the reset control sequencer.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic [2:0] src_r = 3'h0;
	logic bus_end = 1'b1;
	logic [15:0] data = 16'hA5C3;
	logic bus_err_n = 1'b0;
	logic three_state = 1'b0;
	logic brk_n = 1'b0;
	logic lock_r = 1'b0;
	logic pull_r = 1'b0;
	logic [8:0] lag_r = 9'h000;
	logic wire_lvl, oe, master, dis, cfg_err, bdm, fetch, boot_n, pins, hz;
	logic pin_out;
	logic [15:0] cfg;
	logic [4:0] cause;
	int n_fail = 0;
	int compares = 0;
	// The system clock, 100 MHz.
	always #5 i_clock = ~i_clock;
	rcs_top #(.N_INT(3), .BUS_TIMEOUT(4)) rcs_top_inst (
		.i_clock(i_clock), .i_rst(i_rst), .i_reset_pin(wire_lvl),
		.i_internal_reset_src(src_r), .i_bus_cycle_end(bus_end),
		.i_pll_lock(lock_r), .i_data_bus(data),
		.i_bus_error_input_n(bus_err_n),
		.i_three_state_control(three_state), .i_breakpoint_request_n(brk_n),
		.o_reset_pin_out(pin_out), .o_reset_pin_oe(oe),
		.o_master_reset(master),
		.o_module_reset(), .o_abort(), .o_pins_inactive(pins),
		.o_port_high_z(hz), .o_drivers_disabled(dis), .o_config_data(cfg),
		.o_config_bus_error(cfg_err), .o_reset_cause_register(cause),
		.o_trace_bit_low(), .o_trace_bit_high(), .o_supervisor(),
		.o_ipl_mask(), .o_vector_base_register(), .o_bdm_enable(bdm),
		.o_vector_fetch(fetch), .o_boot_chip_select_n(boot_n)
	);
	rcs_ext_reset rcs_ext_reset_inst (
		.i_clock(i_clock), .i_oe(oe), .i_pull(pull_r), .i_lag(lag_r),
		.o_wire(wire_lvl)
	);
	// Prints the verdict and stops the run.
	task automatic end_sim;
		if (n_fail == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim
	// One reset sequence: raise a request, then wait for the vector fetch.
	task automatic seq(input logic [2:0] src, input int hold,
		input logic pull, input logic [8:0] lag, input logic [4:0] exp,
		input int n_up, input int n_drv);
		int up;
		int drv;
		int i;
		logic oe_p;
		up = 0;
		drv = 0;
		oe_p = oe;
		repeat (4) @(posedge i_clock);
		src_r <= src;
		lock_r <= 1'b1;
		pull_r <= pull;
		lag_r <= lag;
		for (i = 0; i < 4000; i++) begin
			@(posedge i_clock);
			if (i == hold) begin
				src_r <= 3'h0;
				pull_r <= 1'b0;
			end
			if (up == 2) lag_r <= 9'h000;
			#1;
			if (fetch === 1'b1) break;
			if (oe === 1'b1) begin
				up += (oe_p !== 1'b1);
				drv++;
				`CHK({pins, hz, pin_out}, 3'b110)
			end
			oe_p = oe;
		end
		if (i == 4000) begin
			n_fail++;
			end_sim();
		end
		`CHK(cause, exp)
		`CHK(up, n_up)
		`CHK(drv >= n_drv, 1'b1)
		`CHK({master, boot_n}, 2'b00)
	endtask : seq
	// Main sequence: power-on, internal, external, slow and stuck wire.
	initial begin
		repeat (8) @(posedge i_clock);
		i_rst <= 1'b0;
		seq(3'h0, 0, 1'b0, 9'h000, 5'h01, 0, 512);
		`CHK({cfg, cfg_err, bdm}, {16'hA5C3, 2'b11})
		@(posedge i_clock);
		data <= 16'h5A3C;
		bus_err_n <= 1'b1;
		brk_n <= 1'b1;
		seq(3'h2, 700, 1'b0, 9'h000, 5'h08, 1, 690);
		`CHK({cfg, cfg_err, bdm}, {16'h5A3C, 2'b00})
		seq(3'h5, 1, 1'b0, 9'h000, 5'h04, 1, 512);
		@(posedge i_clock);
		bus_end <= 1'b0;
		seq(3'h0, 20, 1'b1, 9'h000, 5'h02, 1, 512);
		seq(3'h1, 1, 1'b0, 9'h064, 5'h04, 1, 512);
		seq(3'h4, 1, 1'b0, 9'h0FA, 5'h10, 2, 1024);
		@(posedge i_clock);
		three_state <= 1'b1;
		repeat (12) @(posedge i_clock);
		src_r <= 3'h1;
		repeat (20) @(posedge i_clock);
		#1;
		`CHK({dis, oe, boot_n}, 3'b101)
		end_sim();
	end
endmodule : tb_top
